// >>> msch_scheduler.sv
// Receive descriptor FIFO and the per-channel message scheduler
`include "msch_consts.svh"
module msch_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
		logic inReady;
	} msch_fifo_state_type;
	msch_fifo_state_type s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;
	assign push = inValid && s_q.inReady;
	assign pop = outValid && outReady;
	assign outValid = s_q.count != '0;
	assign outData = mem[s_q.rp];
	assign inReady = s_q.inReady;
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wp = AW'(s_q.wp + 1'b1);
		end
		if (pop) begin
			s_d.rp = AW'(s_q.rp + 1'b1);
		end
		s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
		// Ready is registered so the source sees a clean level
		s_d.inReady = s_d.count != (AW+1)'(DEPTH);
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q <= '0;
			s_q.inReady <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[s_q.wp] <= inData;
		end
	end
endmodule

module msch_scheduler (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	output logic txReq,
	output logic [3:0] txChannel,
	output msch_pkg::msch_tx_type txFrame,
	input wire logic txDone,
	input wire logic [2:0] txResult,
	input wire logic [4:0] txReplyLen,
	input wire logic [11:0] probeIdent,
	output logic replyHit,
	output logic [3:0] replyChannel,
	input wire logic rxValid,
	input wire msch_pkg::msch_rx_type rxWord,
	output logic rxReady,
	output logic mbWrEn,
	output logic [3:0] mbWrChannel,
	output logic [4:0] mbWrLen,
	output logic idleMode
);
	import msch_pkg::*;
	msch_state_type s_q, s_d;
	msch_rx_type rxHead;
	logic rxAvail, rxTake;
	logic found, rxFound;
	logic [3:0] sel, rxSel, wrIdx, rdIdx, c;
	logic endTx;

	function automatic logic chanHit(input logic [7:0] a);
		return a >= `MSCH_CH_BASE && a < `MSCH_CH_END;
	endfunction
	function automatic logic [3:0] chanIdx(input logic [7:0] a);
		return 4'(a[7:3] - 5'h02);
	endfunction
	function automatic logic identMatch(input msch_chan_type ch, input logic [11:0] id);
		return ((ch.ident ^ id) & ch.mask) == 12'h000;
	endfunction
	// Producer types that may be queued: data, reply request, deferred reply
	function automatic logic txEligible(input msch_chan_type ch);
		return !ch.txDone && !ch.chanErr && ((!ch.direction && !ch.remote)
			|| (ch.direction && ch.remote) || (ch.direction && !ch.remote && ch.rxDone));
	endfunction
	function automatic logic isProducer(input msch_chan_type ch);
		return !ch.txDone && (ch.direction || !ch.remote);
	endfunction
	// Which channel types accept each kind of finished frame
	function automatic logic rxWants(input msch_chan_type ch, input logic [1:0] kind,
		input logic [11:0] id);
		logic typeOk;
		typeOk = 1'b0;
		case (kind)
			`MSCH_RK_DATA: typeOk = ch.remote && !ch.rxDone;
			`MSCH_RK_REQ: typeOk = ch.direction && !ch.remote && ch.txDone && !ch.rxDone;
			`MSCH_RK_OURREPLY: typeOk = ch.direction && !ch.remote && !ch.txDone && !ch.rxDone
				&& !ch.chanErr;
			`MSCH_RK_ERROR: typeOk = !(ch.txDone && ch.rxDone);
			default: typeOk = 1'b0;
		endcase
		return typeOk && identMatch(ch, id);
	endfunction
	function automatic logic isFail(input logic [2:0] r);
		return r == `MSCH_RES_CV || r == `MSCH_RES_ACK_ERROR_FLAG || r == `MSCH_RES_FRAME_CHECK_ERROR_FLAG;
	endfunction

	msch_fifo #(
		.WIDTH($bits(msch_rx_type)),
		.DEPTH(`MSCH_FIFO_DEPTH)
	) rxQueue (
		.mclk(mclk),
		.reset(reset),
		.inValid(rxValid),
		.inData(rxWord),
		.inReady(rxReady),
		.outValid(rxAvail),
		.outData(rxHead),
		.outReady(rxTake)
	);

	// Descriptors wait in the queue while idle, so a burst is never dropped
	assign rxTake = rxAvail && !s_q.idleMode;
	assign wrIdx = chanIdx(regAddr);
	assign rdIdx = chanIdx(regAddr);
	assign c = s_q.curCh;

	// Lowest number wins because the loop runs downward and the last hit stays
	always_comb begin
		found = 1'b0;
		sel = 4'h0;
		rxFound = 1'b0;
		rxSel = 4'h0;
		for (int k = `MSCH_NUM_CH - 1; k >= 0; k--) begin
			if (txEligible(s_q.ch[k])) begin
				found = 1'b1;
				sel = 4'(k);
			end
			if (rxWants(s_q.ch[k], rxHead.kind, rxHead.ident)) begin
				rxFound = 1'b1;
				rxSel = 4'(k);
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.mbWrEn = 1'b0;
		endTx = 1'b0;
		if (regWr) begin
			if (chanHit(regAddr)) begin
				case (regAddr[2:0])
					`MSCH_CH_ID_HI: s_d.ch[wrIdx].ident[11:4] = regWrData;
					`MSCH_CH_CMD: begin
						s_d.ch[wrIdx].ident[3:0] = regWrData[7:4];
						s_d.ch[wrIdx].direction = regWrData[`MSCH_CMD_DIR_BIT];
						s_d.ch[wrIdx].remote = regWrData[`MSCH_CMD_REM_BIT];
					end
					`MSCH_CH_LEN: begin
						s_d.ch[wrIdx].len = regWrData[7:3];
						s_d.ch[wrIdx].chanErr = regWrData[`MSCH_LEN_ERR_BIT];
						s_d.ch[wrIdx].txDone = regWrData[`MSCH_LEN_TX_BIT];
						s_d.ch[wrIdx].rxDone = regWrData[`MSCH_LEN_RX_BIT];
					end
					`MSCH_CH_MASK_HI: s_d.ch[wrIdx].mask[11:4] = regWrData;
					`MSCH_CH_MASK_LO: s_d.ch[wrIdx].mask[3:0] = regWrData[7:4];
					default: ;
				endcase
			end else begin
				case (regAddr)
					`MSCH_TX_CTRL_ADDR: s_d.maxRetry = regWrData[3:0];
					`MSCH_COMMAND_ADDR: begin
						if (regWrData[`MSCH_COM_REARB_BIT]) begin
							s_d.rearbPend = 1'b1;
						end
						s_d.idleReq = regWrData[`MSCH_COM_IDLE_BIT];
						if (regWrData[`MSCH_COM_ACTI_BIT] && !regWrData[`MSCH_COM_IDLE_BIT]) begin
							s_d.idleMode = 1'b0;
						end
					end
					`MSCH_EVENT_ADDR: s_d.events = s_q.events & ~regWrData;
					default: ;
				endcase
			end
		end
		if (regRd) begin
			if (chanHit(regAddr)) begin
				case (regAddr[2:0])
					`MSCH_CH_ID_HI: s_d.rdData = s_q.ch[rdIdx].ident[11:4];
					`MSCH_CH_CMD: s_d.rdData = {s_q.ch[rdIdx].ident[3:0], s_q.ch[rdIdx].direction,
						s_q.ch[rdIdx].remote, 2'h0};
					`MSCH_CH_LEN: s_d.rdData = {s_q.ch[rdIdx].len, s_q.ch[rdIdx].chanErr,
						s_q.ch[rdIdx].txDone, s_q.ch[rdIdx].rxDone};
					`MSCH_CH_MASK_HI: s_d.rdData = s_q.ch[rdIdx].mask[11:4];
					`MSCH_CH_MASK_LO: s_d.rdData = {s_q.ch[rdIdx].mask[3:0], 4'h0};
					default: s_d.rdData = 8'h00;
				endcase
			end else begin
				case (regAddr)
					`MSCH_TX_CTRL_ADDR: s_d.rdData = {4'h0, s_q.maxRetry};
					`MSCH_COMMAND_ADDR: s_d.rdData = {s_q.idleMode, 5'h00, s_q.idleReq, 1'b0};
					`MSCH_PROGRESS_ADDR: s_d.rdData = {s_q.retriesDone, s_q.curCh};
					`MSCH_FAULT_ADDR: s_d.rdData = s_q.fault;
					`MSCH_EVENT_ADDR: s_d.rdData = s_q.events;
					default: s_d.rdData = 8'h00;
				endcase
			end
		end

		// Frames finished on the bus; hardware sets are applied after host writes so they win
		if (rxTake && rxFound) begin
			case (rxHead.kind)
				`MSCH_RK_DATA: begin
					s_d.ch[rxSel].rxDone = 1'b1;
					s_d.ch[rxSel].ident = rxHead.ident;
					s_d.mbWrEn = 1'b1;
					s_d.mbWrCh = rxSel;
					s_d.mbWrLen = rxHead.len;
					s_d.events[`MSCH_EV_RX_OK] = 1'b1;
				end
				`MSCH_RK_REQ: begin
					s_d.ch[rxSel].rxDone = 1'b1;
					s_d.events[`MSCH_EV_RX_OK] = 1'b1;
				end
				`MSCH_RK_OURREPLY: begin
					s_d.ch[rxSel].txDone = 1'b1;
					s_d.ch[rxSel].rxDone = 1'b1;
					s_d.events[`MSCH_EV_TX_OK] = 1'b1;
				end
				default: begin
					s_d.ch[rxSel].chanErr = 1'b1;
					s_d.events[`MSCH_EV_RX_ERR] = 1'b1;
				end
			endcase
		end

		// In-frame reply lookup, answered one cycle after the probe
		s_d.replyHit = 1'b0;
		s_d.replyCh = 4'h0;
		for (int k = `MSCH_NUM_CH - 1; k >= 0; k--) begin
			if (!s_q.idleMode && rxWants(s_q.ch[k], `MSCH_RK_OURREPLY, probeIdent)) begin
				s_d.replyHit = 1'b1;
				s_d.replyCh = 4'(k);
			end
		end

		case (s_q.phase)
			ST_SCAN: begin
				for (int k = 0; k < `MSCH_NUM_CH; k++) begin
					if (s_q.ch[k].chanErr && isProducer(s_q.ch[k])) begin
						s_d.ch[k].txDone = 1'b1;
					end
				end
				if (!found) begin
					s_d.rearbSeen = 1'b0;
					s_d.rearbCut = 1'b0;
				end
				if (s_q.idleReq && !s_q.idleMode && (!s_q.rearbSeen || !found)) begin
					s_d.idleMode = 1'b1;
				end else if (found && !s_q.idleMode) begin
					if (s_q.rearbCut && sel == s_q.suspCh) begin
						// No lower-numbered channel was enabled, so the cut channel is dropped
						s_d.ch[sel].txDone = 1'b1;
						s_d.rearbCut = 1'b0;
					end else begin
						s_d.curCh = sel;
						s_d.retryCnt = s_q.maxRetry;
						s_d.retriesDone = 4'h0;
						s_d.tx.ident = s_q.ch[sel].ident;
						s_d.tx.direction = s_q.ch[sel].direction;
						s_d.tx.remote = s_q.ch[sel].remote;
						s_d.tx.len = s_q.ch[sel].len;
						s_d.txReq = 1'b1;
						s_d.rearbCut = 1'b0;
						s_d.phase = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				if (txDone) begin
					case (txResult)
						`MSCH_RES_OK: begin
							s_d.ch[c].txDone = 1'b1;
							s_d.events[`MSCH_EV_TX_OK] = 1'b1;
							endTx = 1'b1;
						end
						`MSCH_RES_OK_REPLY: begin
							// Both flags in one update, never via the waiting state
							s_d.ch[c].txDone = 1'b1;
							if (!s_q.ch[c].rxDone) begin
								s_d.ch[c].rxDone = 1'b1;
								s_d.mbWrEn = 1'b1;
								s_d.mbWrCh = c;
								s_d.mbWrLen = txReplyLen;
							end
							s_d.events[`MSCH_EV_TX_OK] = 1'b1;
							s_d.events[`MSCH_EV_RX_OK] = 1'b1;
							endTx = 1'b1;
						end
						`MSCH_RES_CONTENTION: ;
						default: begin
							if (isFail(txResult)) begin
								s_d.fault = 8'h00;
								s_d.fault[`MSCH_FLT_CV] = txResult == `MSCH_RES_CV;
								s_d.fault[`MSCH_FLT_ACK_ERROR_FLAG] = txResult == `MSCH_RES_ACK_ERROR_FLAG;
								s_d.fault[`MSCH_FLT_FRAME_CHECK_ERROR_FLAG] = txResult == `MSCH_RES_FRAME_CHECK_ERROR_FLAG;
								if (s_q.retryCnt == 4'h0) begin
									s_d.ch[c].txDone = 1'b1;
									s_d.ch[c].chanErr = 1'b1;
									s_d.events[`MSCH_EV_TE] = 1'b1;
									endTx = 1'b1;
								end else begin
									s_d.retryCnt = s_q.retryCnt - 4'h1;
									s_d.retriesDone = s_q.retriesDone + 4'h1;
								end
							end
						end
					endcase
					if (!endTx && s_q.ch[c].chanErr) begin
						s_d.ch[c].txDone = 1'b1;
						endTx = 1'b1;
					end else if (!endTx && s_q.rearbPend) begin
						// The cut channel keeps its enable and is picked up again by the scan
						s_d.rearbCut = 1'b1;
						s_d.suspCh = c;
						s_d.rearbSeen = 1'b1;
						endTx = 1'b1;
					end
					if (endTx) begin
						s_d.rearbPend = 1'b0;
						s_d.txReq = 1'b0;
						s_d.phase = ST_SCAN;
					end
				end
			end
			default: s_d.phase = ST_SCAN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q <= '0;
			s_q.idleMode <= 1'b1;
			s_q.maxRetry <= `MSCH_MAX_RETRY_RESET;
			for (int k = 0; k < `MSCH_NUM_CH; k++) begin
				s_q.ch[k].txDone <= 1'b1;
				s_q.ch[k].rxDone <= 1'b1;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign txReq = s_q.txReq;
	assign txChannel = s_q.curCh;
	assign txFrame = s_q.tx;
	assign replyHit = s_q.replyHit;
	assign replyChannel = s_q.replyCh;
	assign mbWrEn = s_q.mbWrEn;
	assign mbWrChannel = s_q.mbWrCh;
	assign mbWrLen = s_q.mbWrLen;
	assign idleMode = s_q.idleMode;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	property p_retry_exhaust;
		s_q.phase == ST_SEND && txDone && isFail(txResult) && s_q.retryCnt == 4'h0
			|=> s_q.events[`MSCH_EV_TE] && !s_q.txReq && s_q.ch[s_q.curCh].txDone;
	endproperty
	a_retry_exhaust: assert property (p_retry_exhaust) else $error("retry exhaustion not flagged");

	property p_retry_count;
		s_q.phase == ST_SEND && txDone && isFail(txResult) && s_q.retryCnt != 4'h0
			|=> s_q.retryCnt == $past(s_q.retryCnt) - 4'h1 && s_q.retriesDone == $past(s_q.retriesDone) + 4'h1;
	endproperty
	a_retry_count: assert property (p_retry_count) else $error("retry count step wrong");

	property p_contention;
		s_q.phase == ST_SEND && txDone && txResult == `MSCH_RES_CONTENTION |=> $stable(s_q.retryCnt);
	endproperty
	a_contention: assert property (p_contention) else $error("contention changed retry count");

	property p_tx_hold;
		s_q.txReq && !txDone |=> s_q.txReq && $stable(s_q.curCh) && $stable(s_q.tx);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit request dropped mid attempt");

	property p_idle_waits;
		s_q.txReq |-> !s_q.idleMode;
	endproperty
	a_idle_waits: assert property (p_idle_waits) else $error("idle entered while sending");

	property p_progress;
		regRd && !regWr && regAddr == `MSCH_PROGRESS_ADDR
			|=> regRdData == {$past(s_q.retriesDone), $past(s_q.curCh)};
	endproperty
	a_progress: assert property (p_progress) else $error("progress register mismatch");

	property p_reply_pair;
		s_q.phase == ST_SEND && txDone && txResult == `MSCH_RES_OK_REPLY
			|=> s_q.ch[s_q.curCh].txDone && s_q.ch[s_q.curCh].rxDone && !s_q.txReq;
	endproperty
	a_reply_pair: assert property (p_reply_pair) else $error("in-frame reply flags not paired");

	property p_store_sets_rx;
		// Past index comes from the next-state copy, which named this store a cycle ago
		mbWrEn |-> s_q.ch[mbWrChannel].rxDone && !$past(s_q.ch[s_d.mbWrCh].rxDone);
	endproperty
	a_store_sets_rx: assert property (p_store_sets_rx) else $error("store without fresh rx done");

	property p_select_lowest;
		s_q.phase == ST_SCAN && !s_q.idleMode && !s_q.idleReq && found && !s_q.rearbCut
			|=> s_q.txReq && s_q.curCh == $past(sel);
	endproperty
	a_select_lowest: assert property (p_select_lowest) else $error("scan did not start lowest channel");
endmodule

// >>> msch_consts.svh
// Offsets, field positions, reset values and codes of the channel message scheduler
// Summary of operation
// - Type 0,0,0: send data frame until success or retries exhausted, then set tx done.
// - Type 0,1,x,0: send nothing, store matching frame with its length, set rx done.
// - A data frame match writes the received identifier back into the channel.
// - Type 1,1,0,0: send reply request; without in-frame reply set tx done, wait.
// - An in-frame reply to our request sets tx done and rx done together.
// - Type 1,1,1,0: only listen for the deferred reply, then set rx done.
// - Type 1,0,0,0: give in-frame reply to matching request, then set both flags.
// - Type 1,0,0,1: send deferred reply at once, set tx done when sent.
// - Type 1,0,1,0: detect matching reply request, set rx done, no reply sent.
// - Both done flags means inactive; 1,1,0,1 still requests but never stores.
// - Lowest numbered matching channel takes a frame; lowest ready channel transmits.
// - Retries, rearbitration and abort act only on frames this device produces.
// - Retry counter loads on enable, counts failures, at zero stops and flags error.
// - A retry limit of N gives N plus one attempts.
// - Retries done and current channel are readable in the progress register.
// - Only code, acknowledge and check errors count; contention retries without limit.
// - One retry counter and one limit serve every channel.
// - Rearbitrate: finish attempt, serve lower-numbered channel, then resume the interrupted one.
// - Idle after rearbitrate waits until all pending transmissions finish.
// - After rearbitrate with no lower-numbered channel enabled, stop the current channel.
// - Host sets channel error to abort an unsent channel; device then sets tx done.
// - Device sets done and error flags; host clears them to arm a channel.
`ifndef MSCH_CONSTS_SVH
`define MSCH_CONSTS_SVH
`define MSCH_NUM_CH 14
`define MSCH_FIFO_DEPTH 32
`define MSCH_TX_CTRL_ADDR 8'h01
`define MSCH_COMMAND_ADDR 8'h03
`define MSCH_PROGRESS_ADDR 8'h05
`define MSCH_FAULT_ADDR 8'h07
`define MSCH_EVENT_ADDR 8'h09
`define MSCH_CH_BASE 8'h10
`define MSCH_CH_END 8'h80
`define MSCH_CH_ID_HI 3'h0
`define MSCH_CH_CMD 3'h1
`define MSCH_CH_LEN 3'h3
`define MSCH_CH_MASK_HI 3'h6
`define MSCH_CH_MASK_LO 3'h7
`define MSCH_CMD_DIR_BIT 3
`define MSCH_CMD_REM_BIT 2
`define MSCH_LEN_ERR_BIT 2
`define MSCH_LEN_TX_BIT 1
`define MSCH_LEN_RX_BIT 0
`define MSCH_COM_REARB_BIT 0
`define MSCH_COM_IDLE_BIT 1
`define MSCH_COM_ACTI_BIT 2
`define MSCH_COM_STATE_BIT 7
`define MSCH_EV_TX_OK 0
`define MSCH_EV_RX_OK 1
`define MSCH_EV_TE 2
`define MSCH_EV_RX_ERR 3
`define MSCH_FLT_FRAME_CHECK_ERROR_FLAG 0
`define MSCH_FLT_ACK_ERROR_FLAG 1
`define MSCH_FLT_CV 2
`define MSCH_RES_OK 3'h0
`define MSCH_RES_OK_REPLY 3'h1
`define MSCH_RES_CONTENTION 3'h2
`define MSCH_RES_CV 3'h3
`define MSCH_RES_ACK_ERROR_FLAG 3'h4
`define MSCH_RES_FRAME_CHECK_ERROR_FLAG 3'h5
`define MSCH_RK_DATA 2'h0
`define MSCH_RK_REQ 2'h1
`define MSCH_RK_OURREPLY 2'h2
`define MSCH_RK_ERROR 2'h3
`define MSCH_MAX_RETRY_RESET 4'h0
`endif

// >>> msch_pkg.sv
// Types shared by the channel message scheduler
`include "msch_consts.svh"
package msch_pkg;
	typedef struct packed {
		logic [11:0] ident;
		logic [11:0] mask;
		logic [4:0] len;
		logic direction;
		logic remote;
		logic chanErr;
		logic txDone;
		logic rxDone;
	} msch_chan_type;
	typedef struct packed {
		logic [11:0] ident;
		logic [1:0] kind;
		logic [4:0] len;
	} msch_rx_type;
	typedef struct packed {
		logic [11:0] ident;
		logic direction;
		logic remote;
		logic [4:0] len;
	} msch_tx_type;
	typedef enum logic {ST_SCAN, ST_SEND} msch_phase_type;
	typedef struct packed {
		msch_chan_type [`MSCH_NUM_CH-1:0] ch;
		msch_phase_type phase;
		logic [3:0] maxRetry;
		logic [3:0] retryCnt;
		logic [3:0] retriesDone;
		logic [3:0] curCh;
		logic [3:0] suspCh;
		logic rearbPend;
		logic rearbCut;
		logic rearbSeen;
		logic idleReq;
		logic idleMode;
		logic [7:0] fault;
		logic [7:0] events;
		logic [7:0] rdData;
		logic txReq;
		msch_tx_type tx;
		logic replyHit;
		logic [3:0] replyCh;
		logic mbWrEn;
		logic [3:0] mbWrCh;
		logic [4:0] mbWrLen;
	} msch_state_type;
endpackage

// >>> msch_link_model.sv
// Far-side link model: answers transmit attempts and feeds receive descriptors
`include "msch_consts.svh"
module msch_link_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic txReq,
	output logic txDone,
	output logic [2:0] txResult,
	output logic [4:0] txReplyLen,
	output logic rxValid,
	output msch_pkg::msch_rx_type rxWord,
	input wire logic rxReady
);
	timeunit 1ns;
	timeprecision 1ps;
	import msch_pkg::*;
	logic [2:0] resQ[$];
	msch_rx_type rxQ[$];
	int attempts = 0;
	initial begin
		txDone = 1'b0;
		txResult = 3'h7;
		txReplyLen = 5'h00;
		rxValid = 1'b0;
		rxWord = '1;
	end
	// Outcomes come from the bench queue, plain success once it runs dry
	always begin
		@(negedge mclk);
		if (txReq === 1'b1 && reset === 1'b0) begin
			repeat (3) @(negedge mclk);
			txResult = resQ.size() ? resQ.pop_front() : `MSCH_RES_OK;
			// Any in-frame reply is reported with length four
			txReplyLen = 5'h04;
			txDone = 1'b1;
			attempts++;
			@(negedge mclk);
			txDone = 1'b0;
			// Stale result is inverted so nothing can lean on it
			txResult = ~txResult;
			txReplyLen = ~txReplyLen;
			@(negedge mclk);
		end
	end
	always @(posedge mclk) begin
		if (rxValid === 1'b1 && rxReady === 1'b1) begin
			void'(rxQ.pop_front());
		end
	end
	// Head of queue held until taken; an empty queue shows a changing pattern
	always @(negedge mclk) begin
		rxValid <= rxQ.size() > 0;
		rxWord <= rxQ.size() ? rxQ[0] : ~rxWord;
	end
endmodule

// >>> tb.sv
// Bench for the channel message scheduler: register tasks and a scenario sequence
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import msch_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic [11:0] probeIdent = 12'h000;
	logic txReq, txDone, replyHit, rxValid, rxReady, mbWrEn, idleMode;
	logic [3:0] txChannel, replyChannel, mbWrChannel;
	logic [2:0] txResult;
	logic [4:0] txReplyLen, mbWrLen;
	msch_tx_type txFrame;
	msch_rx_type rxWord;
	int n_errors = 0, checked = 0, cyc = 0;
	msch_scheduler dut_u (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txReq(txReq), .txChannel(txChannel),
		.txFrame(txFrame), .txDone(txDone), .txResult(txResult), .txReplyLen(txReplyLen),
		.probeIdent(probeIdent), .replyHit(replyHit), .replyChannel(replyChannel), .rxValid(rxValid),
		.rxWord(rxWord), .rxReady(rxReady), .mbWrEn(mbWrEn), .mbWrChannel(mbWrChannel),
		.mbWrLen(mbWrLen), .idleMode(idleMode));
	msch_link_model link_u (.mclk(mclk), .reset(reset), .txReq(txReq), .txDone(txDone),
		.txResult(txResult), .txReplyLen(txReplyLen), .rxValid(rxValid), .rxWord(rxWord),
		.rxReady(rxReady));
	initial forever #2 mclk = ~mclk;
	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is a few hundred cycles, so this only trips on a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWr = 1'b1;
		@(negedge mclk);
		regWr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		regRd = 1'b1;
		@(negedge mclk);
		regRd = 1'b0;
		chk($sformatf("reg %h", a), {8'h00, regRdData}, {8'h00, exp});
		@(negedge mclk);
	endtask
	function automatic logic sig(input int s);
		return s == 0 ? txReq : (s == 1 ? idleMode : mbWrEn);
	endfunction
	task automatic wt(input string nm, input int s, input logic lvl);
		for (int i = 0; i < 300 && sig(s) !== lvl; i++) @(negedge mclk);
		chk(nm, {15'h0000, sig(s)}, {15'h0000, lvl});
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		@(negedge mclk);
		chk("idleMode", {15'h0000, idleMode}, 16'h0001);
		rdc(8'h13, 8'h03);
		rdc(8'h05, 8'h00);
		rdc(8'h0b, 8'h00);
		// Idle holds descriptors, so 33 pushes overfill the 32-word buffer
		for (int i = 0; i < 33; i++) link_u.rxQ.push_back({12'hfff, 2'h0, 5'h01});
		repeat (45) @(negedge mclk);
		chk("rxReady", {15'h0000, rxReady}, 16'h0000);
		chk("rxQ", 16'(link_u.rxQ.size()), 16'h0001);
		wr(8'h03, 8'h04);
		wt("idleMode", 1, 1'b0);
		repeat (45) @(negedge mclk);
		chk("rxQ", 16'(link_u.rxQ.size()), 16'h0000);
		// One retry allowed; two counted failures exhaust it
		wr(8'h01, 8'h01);
		link_u.resQ = '{3'h4, 3'h5};
		link_u.attempts = 0;
		wr(8'h10, 8'hab);
		wr(8'h11, 8'h50);
		wr(8'h13, 8'h10);
		wt("txReq", 0, 1'b1);
		chk("txChannel", {12'h000, txChannel}, 16'h0000);
		chk("txIdent", {4'h0, txFrame.ident}, 16'h0ab5);
		wt("txReq", 0, 1'b0);
		chk("attempts", 16'(link_u.attempts), 16'h0002);
		rdc(8'h13, 8'h16);
		rdc(8'h07, 8'h01);
		rdc(8'h05, 8'h10);
		rdc(8'h09, 8'h04);
		wr(8'h09, 8'hff);
		// Contention does not consume retries
		link_u.resQ = '{3'h2, 3'h2, 3'h2};
		link_u.attempts = 0;
		wr(8'h13, 8'h10);
		wt("txReq", 0, 1'b1);
		wt("txReq", 0, 1'b0);
		chk("attempts", 16'(link_u.attempts), 16'h0004);
		rdc(8'h13, 8'h12);
		rdc(8'h09, 8'h01);
		wr(8'h09, 8'hff);
		// Channels 1 and 3 armed and 5 aborted, all while idle
		wr(8'h03, 8'h02);
		wt("idleMode", 1, 1'b1);
		wr(8'h1b, 8'h10);
		wr(8'h2b, 8'h10);
		wr(8'h3b, 8'h14);
		wr(8'h03, 8'h04);
		wt("txReq", 0, 1'b1);
		chk("txChannel", {12'h000, txChannel}, 16'h0001);
		wt("txReq", 0, 1'b0);
		wt("txReq", 0, 1'b1);
		chk("txChannel", {12'h000, txChannel}, 16'h0003);
		wt("txReq", 0, 1'b0);
		repeat (20) @(negedge mclk);
		chk("txReq", {15'h0000, txReq}, 16'h0000);
		rdc(8'h3b, 8'h16);
		wr(8'h09, 8'hff);
		// Channels 6 and 7 listen on one masked identifier
		for (int k = 8'h40; k < 8'h50; k += 8) begin
			wr(8'(k), 8'h12);
			wr(8'(k + 1), 8'h04);
			wr(8'(k + 6), 8'hff);
			wr(8'(k + 7), 8'h00);
			wr(8'(k + 3), 8'h22);
		end
		link_u.rxQ.push_back({12'h12a, 2'h0, 5'h03});
		wt("mbWrEn", 2, 1'b1);
		chk("mbWr", {mbWrChannel, 7'h00, mbWrLen}, {4'h6, 7'h00, 5'h03});
		rdc(8'h43, 8'h23);
		rdc(8'h41, 8'ha4);
		link_u.rxQ.push_back({12'h12b, 2'h0, 5'h03});
		wt("mbWrEn", 2, 1'b1);
		chk("mbWr", {mbWrChannel, 7'h00, mbWrLen}, {4'h7, 7'h00, 5'h03});
		rdc(8'h49, 8'hb4);
		rdc(8'h09, 8'h02);
		// No reply request is ever armed here, so no other node can beat it
		wr(8'h30, 8'h45);
		wr(8'h31, 8'h68);
		wr(8'h36, 8'hff);
		wr(8'h37, 8'hf0);
		wr(8'h33, 8'h10);
		probeIdent = 12'h456;
		repeat (2) @(negedge mclk);
		chk("reply", {11'h000, replyHit, replyChannel}, {11'h000, 1'b1, 4'h4});
		// Our in-frame reply went out: the immediate reply channel turns inactive
		wr(8'h09, 8'hff);
		link_u.rxQ.push_back({12'h456, 2'h2, 5'h00});
		repeat (6) @(negedge mclk);
		rdc(8'h33, 8'h13);
		rdc(8'h09, 8'h01);
		chk("reply", {15'h0000, replyHit}, 16'h0000);
		// Reply request answered in frame: both flags at once, reply stored
		link_u.resQ = '{3'h1};
		wr(8'h20, 8'h33);
		wr(8'h21, 8'h0c);
		wr(8'h23, 8'h10);
		wt("mbWrEn", 2, 1'b1);
		chk("mbWr", {mbWrChannel, 7'h00, mbWrLen}, {4'h2, 7'h00, 5'h04});
		rdc(8'h23, 8'h13);
		// Channel 8 is cut after a failed attempt, channel 1 served, then 8 resumes
		link_u.resQ = '{3'h4, 3'h0, 3'h0};
		wr(8'h53, 8'h10);
		wt("txReq", 0, 1'b1);
		wr(8'h03, 8'h01);
		wr(8'h1b, 8'h10);
		wt("txReq", 0, 1'b0);
		wt("txReq", 0, 1'b1);
		chk("txChannel", {12'h000, txChannel}, 16'h0001);
		wt("txReq", 0, 1'b0);
		wt("txReq", 0, 1'b1);
		chk("txChannel", {12'h000, txChannel}, 16'h0008);
		wt("txReq", 0, 1'b0);
		rdc(8'h05, 8'h08);
		rdc(8'h53, 8'h12);
		// With nothing else enabled the cut channel is dropped
		link_u.resQ = '{3'h4};
		link_u.attempts = 0;
		wr(8'h53, 8'h10);
		wt("txReq", 0, 1'b1);
		wr(8'h03, 8'h01);
		wt("txReq", 0, 1'b0);
		repeat (20) @(negedge mclk);
		chk("attempts", 16'(link_u.attempts), 16'h0001);
		rdc(8'h53, 8'h12);
		report_and_stop();
	end
endmodule
